// ==== core/e8fio_blink.sv ====
`timescale 1ns/1ps
module e8fio_blink #(
  parameter int unsigned HALF_CYC = e8fio_pkg::FLASH_HALF_CYC
) (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  output logic      blink_ff
);
  import e8fio_pkg::*;

  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic        nxt_blink;

  // Free-running half-period counter
  always_comb begin
    nxt_cnt   = cnt_ff + 32'h1;
    nxt_blink = blink_ff;
    if (cnt_ff >= 32'(HALF_CYC - 1)) begin
      nxt_cnt   = 32'h0;
      nxt_blink = ~blink_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff   <= 32'h0;
      blink_ff <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      blink_ff <= nxt_blink;
    end
  end

endmodule : e8fio_blink

// ==== core/e8fio_pkg.sv ====
package e8fio_pkg;

  // Clock rate
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned CLK_KHZ = 40_000;

  // Fast flash of the indicators, half period
  localparam int unsigned FLASH_HALF_US  = 178_571;
  localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_US * CLK_MHZ;

  // Silence on the request port that counts as lost traffic
  localparam int unsigned MB_TIMEOUT_MS  = 1000;
  localparam int unsigned MB_TIMEOUT_CYC = MB_TIMEOUT_MS * CLK_KHZ;

  // Output channels and groups
  localparam int NUM_OUT = 8;
  localparam int GRP_W   = 4;
  localparam int NUM_GRP = 2;
  localparam int SW_W    = 4;

  // Function codes of the request port
  localparam logic [7:0] FC_READ_HOLD   = 8'h03;
  localparam logic [7:0] FC_READ_INPUT  = 8'h04;
  localparam logic [7:0] FC_WRITE_MULTI = 8'h10;

  // Process image: two command words, two short-circuit words
  localparam int         IDX_W        = 4;
  localparam int         WORD_W       = 16;
  localparam logic [3:0] IMG_WORDS    = 4'h2;
  localparam logic [3:0] IDX_CMD_OUT  = 4'h0;
  localparam logic [3:0] IDX_CMD_AUX  = 4'h1;
  localparam logic [3:0] IDX_SC_OUT   = 4'h0;
  localparam logic [3:0] IDX_SC_GRP   = 4'h1;
  localparam logic [15:0] CMD_RESET   = 16'h0000;
  localparam logic [15:0] DATA_NONE   = 16'h0000;

  // Node address setting, two decimal digits
  localparam int         NODE_W    = 7;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [6:0] BCD_SCALE = 7'h0a;
  localparam logic [6:0] ADDR_NONE = 7'h00;

  // Link progress, Gray coded along off, config, cyclic, lost
  typedef enum logic [1:0] {
    COMM_OFF  = 2'b00,
    COMM_CFG  = 2'b01,
    COMM_CYC  = 2'b11,
    COMM_LOST = 2'b10
  } e8fio_comm_t;

endpackage : e8fio_pkg

// ==== core/e8fio_top.sv ====
// How it works
// - On link fault, groups clear or hold
// - Switch changes take effect at once
// - Switch 1 picks hold for outputs 1-4
// - Switch 2 picks hold for outputs 5-8
// - Switches 3 and 4 are ignored
// - Comm light: off, flashing, or steady
// - I/O mode: fault flashes on missing partner
// - Modbus mode: flash on silence or short
// - Fault steady on critical error, else flashing or off
// - Output lights show state, group 1 flashes on a short in outputs 1-4
// - Group 2 lights flash on a short in outputs 5-8
// - Address 01 to 99 valid, 00 unset
// - Four 16-bit words in process image
// - Command words read 03, written 16
`timescale 1ns/1ps
module e8fio_top #(
  parameter int unsigned FLASH_HALF_CYC = e8fio_pkg::FLASH_HALF_CYC,
  parameter int unsigned MB_TIMEOUT_CYC = e8fio_pkg::MB_TIMEOUT_CYC
) (
  input  wire logic                          clk_sys,
  input  wire logic                          arst_n,
  input  wire logic [e8fio_pkg::SW_W-1:0]    sw_cfg,
  input  wire logic [3:0]                    addr_tens,
  input  wire logic [3:0]                    addr_ones,
  input  wire logic                          link_ok,
  input  wire logic                          io_mode,
  input  wire logic                          config_mode,
  input  wire logic                          input_module_found,
  input  wire logic                          crit_err,
  input  wire logic [e8fio_pkg::NUM_OUT-1:0] sc_det,
  input  wire logic                          req_valid,
  input  wire logic [7:0]                    req_fc,
  input  wire logic [e8fio_pkg::IDX_W-1:0]   req_index,
  input  wire logic [e8fio_pkg::WORD_W-1:0]  req_wdata,
  output logic                               resp_valid_ff,
  output logic                               resp_exc_ff,
  output logic [e8fio_pkg::WORD_W-1:0]       resp_data_ff,
  output logic [e8fio_pkg::NUM_OUT-1:0]      dout_ff,
  output logic [e8fio_pkg::NUM_OUT-1:0]      per_output_indicators_ff,
  output logic                               comm_indicator_ff,
  output logic                               fault_indicator_ff,
  output logic                               supply_indicator_ff,
  output logic [e8fio_pkg::NODE_W-1:0]       node_addr_ff,
  output logic                               addressed_ff
);
  import e8fio_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Declarations
  logic                blink;
  logic [NODE_W-1:0]   nxt_node_addr;
  logic                nxt_addressed;
  logic [WORD_W-1:0]   cmd_ff [NUM_GRP];
  logic [WORD_W-1:0]   nxt_cmd [NUM_GRP];
  logic                nxt_resp_valid;
  logic                nxt_resp_exc;
  logic [WORD_W-1:0]   nxt_resp_data;
  logic [WORD_W-1:0]   sc_word [NUM_GRP];
  logic [NUM_OUT-1:0]  sc_ff;
  logic [NUM_GRP-1:0]  grp_sc;
  logic [NUM_GRP-1:0]  grp_hold;
  logic                take;
  logic                idx_ok;
  logic [31:0]         mb_cnt_ff;
  logic [31:0]         nxt_mb_cnt;
  logic                mb_lost_ff;
  logic                nxt_mb_lost;
  e8fio_comm_t         comm_ff;
  e8fio_comm_t         nxt_comm;
  logic                comm_fault;
  logic                flash_cond;
  logic                nxt_comm_ind;
  logic                nxt_fault_ind;
  logic [NUM_OUT-1:0]  nxt_dout;
  logic [NUM_OUT-1:0]  nxt_ind;

  //////////////////////////////////////////////////////////////////////////
  // Flash source for the comm, fault and output indicators; the supply light stays steady
  e8fio_blink #(
    .HALF_CYC (FLASH_HALF_CYC)
  ) u_blink (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .blink_ff (blink)
  );

  //////////////////////////////////////////////////////////////////////////
  // Node address decode from the two digit wheels
  always_comb begin
    nxt_node_addr = ADDR_NONE;
    nxt_addressed = 1'b0;
    if (addr_tens <= DIGIT_MAX && addr_ones <= DIGIT_MAX) begin
      nxt_node_addr = NODE_W'(addr_tens) * BCD_SCALE + NODE_W'(addr_ones);
      nxt_addressed = (nxt_node_addr != ADDR_NONE);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      node_addr_ff <= ADDR_NONE;
      addressed_ff <= 1'b0;
    end else begin
      node_addr_ff <= nxt_node_addr;
      addressed_ff <= nxt_addressed;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Process image access: commands and short-circuit words
  assign sc_word[0] = WORD_W'(sc_ff);
  assign sc_word[1] = WORD_W'(grp_sc);
  assign take       = req_valid && addressed_ff;
  assign idx_ok     = (req_index < IMG_WORDS);

  always_comb begin
    nxt_cmd        = cmd_ff;
    nxt_resp_valid = take;
    nxt_resp_exc   = 1'b0;
    nxt_resp_data  = DATA_NONE;
    if (take) begin
      case (req_fc)
        FC_READ_HOLD: begin
          if (idx_ok) nxt_resp_data = cmd_ff[req_index[0]];
          else nxt_resp_exc = 1'b1;
        end
        FC_WRITE_MULTI: begin
          if (idx_ok) begin
            nxt_cmd[req_index[0]] = req_wdata;
            nxt_resp_data         = req_wdata;
          end else begin
            nxt_resp_exc = 1'b1;
          end
        end
        FC_READ_INPUT: begin
          if (idx_ok) nxt_resp_data = sc_word[req_index[0]];
          else nxt_resp_exc = 1'b1;
        end
        default: nxt_resp_exc = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cmd_ff[0]     <= CMD_RESET;
      cmd_ff[1]     <= CMD_RESET;
      resp_valid_ff <= 1'b0;
      resp_exc_ff   <= 1'b0;
      resp_data_ff  <= DATA_NONE;
      sc_ff         <= '0;
    end else begin
      cmd_ff        <= nxt_cmd;
      resp_valid_ff <= nxt_resp_valid;
      resp_exc_ff   <= nxt_resp_exc;
      resp_data_ff  <= nxt_resp_data;
      sc_ff         <= sc_det;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Traffic watchdog; any taken request restarts it
  always_comb begin
    nxt_mb_cnt  = mb_cnt_ff;
    nxt_mb_lost = mb_lost_ff;
    if (take) begin
      nxt_mb_cnt  = 32'h0;
      nxt_mb_lost = 1'b0;
    end else if (mb_cnt_ff >= 32'(MB_TIMEOUT_CYC - 1)) begin
      nxt_mb_lost = 1'b1;
    end else begin
      nxt_mb_cnt = mb_cnt_ff + 32'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mb_cnt_ff  <= 32'h0;
      mb_lost_ff <= 1'b1;
    end else begin
      mb_cnt_ff  <= nxt_mb_cnt;
      mb_lost_ff <= nxt_mb_lost;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Link progress state machine
  always_comb begin
    nxt_comm = comm_ff;
    case (comm_ff)
      COMM_OFF: begin
        if (link_ok) nxt_comm = COMM_CFG;
      end
      COMM_CFG: begin
        if (!link_ok) nxt_comm = COMM_OFF;
        else if (addressed_ff && !config_mode) nxt_comm = COMM_CYC;
      end
      COMM_CYC: begin
        if (!link_ok) nxt_comm = COMM_OFF;
        else if (!addressed_ff || config_mode) nxt_comm = COMM_CFG;
        else if (!io_mode && mb_lost_ff) nxt_comm = COMM_LOST;
      end
      COMM_LOST: begin
        if (!link_ok) nxt_comm = COMM_OFF;
        else if (!addressed_ff || config_mode) nxt_comm = COMM_CFG;
        else if (io_mode || !mb_lost_ff) nxt_comm = COMM_CYC;
      end
      default: nxt_comm = COMM_OFF;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) comm_ff <= COMM_OFF;
    else comm_ff <= nxt_comm;
  end

  //////////////////////////////////////////////////////////////////////////
  // Fault behaviour per group, switches read live every cycle
  assign comm_fault = (comm_ff != COMM_CYC);
  assign grp_hold   = sw_cfg[NUM_GRP-1:0];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
      if (gi % GRP_W == 0) begin : g_grp
        assign grp_sc[gi/GRP_W] = |sc_ff[gi +: GRP_W];
      end
      // Command, or safe state whenever the link is not in cyclic exchange
      assign nxt_dout[gi] = comm_fault
                          ? (grp_hold[gi/GRP_W] & dout_ff[gi])
                          : cmd_ff[IDX_CMD_OUT[0]][gi];
      // Output state, or group flash on a short
      assign nxt_ind[gi]  = grp_sc[gi/GRP_W] ? blink : dout_ff[gi];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Indicators
  always_comb begin
    flash_cond = io_mode
               ? (!input_module_found || !link_ok)
               : (comm_ff == COMM_LOST || !link_ok || |grp_sc);
    case (comm_ff)
      COMM_CYC: nxt_comm_ind = 1'b1;
      COMM_CFG: nxt_comm_ind = blink;
      default:  nxt_comm_ind = 1'b0;
    endcase
    if (crit_err) nxt_fault_ind = 1'b1;
    else if (flash_cond) nxt_fault_ind = blink;
    else nxt_fault_ind = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dout_ff                  <= '0;
      per_output_indicators_ff <= '0;
      comm_indicator_ff        <= 1'b0;
      fault_indicator_ff       <= 1'b0;
      supply_indicator_ff      <= 1'b0;
    end else begin
      dout_ff                  <= nxt_dout;
      per_output_indicators_ff <= nxt_ind;
      comm_indicator_ff        <= nxt_comm_ind;
      fault_indicator_ff       <= nxt_fault_ind;
      supply_indicator_ff      <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence wr_req_s;
    req_valid && addressed_ff && req_fc == FC_WRITE_MULTI
      && req_index == IDX_CMD_OUT;
  endsequence

  sequence cmd_seen_s;
    resp_valid_ff && !resp_exc_ff && cmd_ff[0] == $past(req_wdata);
  endsequence

  clr_lo_a: assert property (
    comm_fault && !sw_cfg[0] |=> dout_ff[GRP_W-1:0] == '0)
    else $error("Group 1 not cleared on fault");

  hold_lo_a: assert property (
    comm_fault && sw_cfg[0] |=> $stable(dout_ff[GRP_W-1:0]))
    else $error("Group 1 not held on fault");

  clr_hi_a: assert property (
    comm_fault && !sw_cfg[1] |=> dout_ff[NUM_OUT-1:GRP_W] == '0)
    else $error("Group 2 not cleared on fault");

  follow_cmd_a: assert property (
    !comm_fault |=> dout_ff == $past(cmd_ff[0][NUM_OUT-1:0]))
    else $error("Outputs do not follow command word");

  write_cmd_a: assert property (
    wr_req_s |=> cmd_seen_s
      ##1 ($past(comm_fault) || dout_ff == $past(req_wdata[NUM_OUT-1:0], 2)))
    else $error("Command write not applied");

  sc_read_a: assert property (
    req_valid && addressed_ff && req_fc == FC_READ_INPUT
      && req_index == IDX_SC_OUT
    |=> resp_valid_ff && resp_data_ff == WORD_W'($past(sc_ff)))
    else $error("Short-circuit word read wrong");

  unaddr_a: assert property (
    !addressed_ff |=> !resp_valid_ff)
    else $error("Answer given while unaddressed");

  crit_on_a: assert property (
    crit_err |=> fault_indicator_ff)
    else $error("Fault light not steady on critical error");

  grp_flash_a: assert property (
    grp_sc[0] |=> per_output_indicators_ff[GRP_W-1:0] == {GRP_W{$past(blink)}})
    else $error("Group 1 lights not flashing on short");

  comm_off_a: assert property (
    !link_ok ##1 !link_ok |=> !comm_indicator_ff)
    else $error("Comm light lit without link");

endmodule : e8fio_top

// ==== test/e8fio_master.sv ====
`timescale 1ns/1ps
module e8fio_master (
  input  wire logic        clk_sys,
  input  wire logic        resp_valid_ff,
  input  wire logic        resp_exc_ff,
  input  wire logic [15:0] resp_data_ff,
  output logic             req_valid,
  output logic [7:0]       req_fc,
  output logic [3:0]       req_index,
  output logic [15:0]      req_wdata
);
  // Idle request port
  initial begin
    req_valid = 1'b0;
    req_fc    = 8'hff;
    req_index = 4'hf;
    req_wdata = 16'hffff;
  end

  // One request strobe, then a bounded wait for the answer
  task automatic xfer(input logic [7:0] fc, input logic [3:0] idx,
                      input logic [15:0] wd, output logic got,
                      output logic exc, output logic [15:0] rd);
    got = 1'b0;
    exc = 1'b0;
    rd  = 16'h0000;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_fc    <= fc;
    req_index <= idx;
    req_wdata <= wd;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    // Released lines show the inverse of the last value
    req_fc    <= ~fc;
    req_index <= ~idx;
    req_wdata <= ~wd;
    // Answer stands for one cycle right after the taking edge
    for (int i = 0; i < 3; i++) begin
      #1;
      if (resp_valid_ff === 1'b1) begin
        got = 1'b1;
        exc = resp_exc_ff;
        rd  = resp_data_ff;
        break;
      end
      @(posedge clk_sys);
    end
  endtask : xfer
endmodule : e8fio_master

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
  import e8fio_pkg::*;
  logic clk_sys, arst_n, link_ok, io_mode, config_mode, found, crit_err;
  logic [3:0]  sw_cfg, addr_tens, addr_ones, req_index;
  logic [7:0]  sc_det, req_fc, dout, poi;
  logic        req_valid, rv, rx, comm, fault, supply, addressed;
  logic [15:0] req_wdata, rd;
  logic [6:0]  node;
  logic [9:0]  hi, lo;
  int          n_fail, num_checks;

  e8fio_top #(.FLASH_HALF_CYC(4), .MB_TIMEOUT_CYC(20)) dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .sw_cfg(sw_cfg),
    .addr_tens(addr_tens), .addr_ones(addr_ones), .link_ok(link_ok),
    .io_mode(io_mode), .config_mode(config_mode),
    .input_module_found(found), .crit_err(crit_err), .sc_det(sc_det),
    .req_valid(req_valid), .req_fc(req_fc), .req_index(req_index),
    .req_wdata(req_wdata), .resp_valid_ff(rv), .resp_exc_ff(rx),
    .resp_data_ff(rd), .dout_ff(dout), .per_output_indicators_ff(poi),
    .comm_indicator_ff(comm), .fault_indicator_ff(fault),
    .supply_indicator_ff(supply), .node_addr_ff(node),
    .addressed_ff(addressed));

  e8fio_master m (
    .clk_sys(clk_sys), .resp_valid_ff(rv), .resp_exc_ff(rx),
    .resp_data_ff(rd), .req_valid(req_valid), .req_fc(req_fc),
    .req_index(req_index), .req_wdata(req_wdata));

  // Clock, 25 ns period
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] g, input logic [15:0] e,
                     input string what);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  // Request with expected answer presence, exception and data
  task automatic rq(input logic [7:0] fc, input logic [3:0] idx,
                    input logic [15:0] wd, input logic eg,
                    input logic ex, input logic [15:0] ed);
    logic g, x;
    logic [15:0] d;
    m.xfer(fc, idx, wd, g, x, d);
    chk({15'h0, g}, {15'h0, eg}, "answer");
    // A missing answer ends the run at the report
    if (eg && !g) close_out();
    if (eg) chk({15'h0, x}, {15'h0, ex}, "exception");
    if (eg) chk(d, ed, "data");
  endtask : rq

  // Sample the lights for 12 cycles, record seen ones and zeros
  task automatic watch;
    hi = 10'h000;
    lo = 10'h000;
    repeat (12) begin
      step(1);
      hi = hi | {poi, comm, fault};
      lo = lo | ~{poi, comm, fault};
    end
  endtask : watch

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] at [6] = '{8'h00, 8'h99, 8'h1a, 8'ha1, 8'h01, 8'h12};
  logic [6:0] ae [6] = '{7'h00, 7'h63, 7'h00, 7'h00, 7'h01, 7'h0c};

  initial begin
    n_fail = 0;
    num_checks = 0;
    arst_n = 1'b0;
    {link_ok, io_mode, config_mode, found, crit_err} = 5'b00010;
    sw_cfg = 4'h0;
    {addr_tens, addr_ones} = 8'h12;
    sc_det = 8'h00;
    step(20);
    arst_n <= 1'b1;
    step(2);
    chk({8'h0, dout}, 16'h0000, "dout after reset");
    chk({15'h0, supply}, 16'h0001, "supply light");
    for (int i = 0; i < 6; i++) begin
      {addr_tens, addr_ones} <= at[i];
      step(3);
      chk({9'h0, node}, {9'h0, ae[i]}, "node address");
      chk({15'h0, addressed}, {15'h0, ae[i] != 7'h0}, "addressed");
      if (ae[i] == 7'h0) rq(FC_READ_HOLD, 4'h0, 16'h0, 1'b0, 1'b0, 16'h0);
    end
    $display("test address done");
    link_ok <= 1'b1;
    config_mode <= 1'b1;
    watch();
    chk({15'h0, hi[1] & lo[1]}, 16'h0001, "comm flash in config");
    config_mode <= 1'b0;
    rq(FC_READ_HOLD, 4'h0, 16'h0, 1'b1, 1'b0, 16'h0000);
    step(2);
    chk({8'h0, dout}, 16'h0000, "dout before command");
    chk({15'h0, comm}, 16'h0001, "comm steady");
    rq(FC_WRITE_MULTI, 4'h0, 16'h00a5, 1'b1, 1'b0, 16'h00a5);
    rq(FC_WRITE_MULTI, 4'h1, 16'h1234, 1'b1, 1'b0, 16'h1234);
    rq(FC_READ_HOLD, 4'h1, 16'h0, 1'b1, 1'b0, 16'h1234);
    rq(8'h05, 4'h0, 16'h0, 1'b1, 1'b1, 16'h0000);
    rq(FC_WRITE_MULTI, 4'h2, 16'hffff, 1'b1, 1'b1, 16'h0000);
    rq(FC_READ_HOLD, 4'h0, 16'h0, 1'b1, 1'b0, 16'h00a5);
    step(2);
    chk({8'h0, dout}, 16'h00a5, "dout follows command");
    $display("test exchange done");
    sw_cfg <= 4'h3;
    step(25);
    chk({8'h0, dout}, 16'h00a5, "hold both groups");
    chk({15'h0, comm}, 16'h0000, "comm off when lost");
    watch();
    chk({15'h0, hi[0] & lo[0]}, 16'h0001, "fault flash on silence");
    sw_cfg <= 4'he;
    step(2);
    chk({8'h0, dout}, 16'h00a0, "group 1 clears at once");
    sw_cfg <= 4'hc;
    step(2);
    chk({8'h0, dout}, 16'h0000, "group 2 clears");
    $display("test fail-safe done");
    sc_det <= 8'h04;
    rq(FC_WRITE_MULTI, 4'h0, 16'h005a, 1'b1, 1'b0, 16'h005a);
    rq(FC_READ_INPUT, 4'h0, 16'h0, 1'b1, 1'b0, 16'h0004);
    rq(FC_READ_INPUT, 4'h1, 16'h0, 1'b1, 1'b0, 16'h0001);
    watch();
    chk({12'h0, hi[5:2] & lo[5:2]}, 16'h000f, "group 1 flashes");
    chk({12'h0, hi[9:6] & lo[9:6]}, 16'h0000, "group 2 steady");
    chk({12'h0, hi[9:6]}, 16'h0005, "group 2 shows state");
    chk({15'h0, hi[0] & lo[0]}, 16'h0001, "fault flash on short");
    sc_det <= 8'h80;
    rq(FC_READ_INPUT, 4'h1, 16'h0, 1'b1, 1'b0, 16'h0002);
    watch();
    chk({12'h0, hi[9:6] & lo[9:6]}, 16'h000f, "group 2 flashes");
    chk({12'h0, hi[5:2] & lo[5:2]}, 16'h0000, "group 1 steady");
    chk({12'h0, hi[5:2]}, 16'h000a, "group 1 shows state");
    sc_det <= 8'h00;
    crit_err <= 1'b1;
    rq(FC_READ_HOLD, 4'h0, 16'h0, 1'b1, 1'b0, 16'h005a);
    step(2);
    chk({15'h0, fault}, 16'h0001, "fault steady on error");
    crit_err <= 1'b0;
    rq(FC_READ_HOLD, 4'h0, 16'h0, 1'b1, 1'b0, 16'h005a);
    step(2);
    chk({15'h0, fault}, 16'h0000, "fault off, no error");
    $display("test lights done");
    io_mode <= 1'b1;
    found <= 1'b0;
    watch();
    chk({15'h0, hi[0] & lo[0]}, 16'h0001, "fault flash, no partner");
    found <= 1'b1;
    step(3);
    chk({15'h0, fault}, 16'h0000, "fault off in I/O mode");
    link_ok <= 1'b0;
    step(3);
    chk({15'h0, comm}, 16'h0000, "comm off without link");
    chk({8'h0, dout}, 16'h0000, "outputs clear on link loss");
    $display("test modes done");
    close_out();
  end
endmodule : tb
